// ---- dcrm_top.v ----
// dual channel redundancy manager with ahb-lite register slave
`include "dcrm_defines.vh"
`default_nettype none
module dcrm_top #(
    parameter SEC_CYC = `DCRM_CLK_HZ,
    parameter FLASH_CYC = `DCRM_CLK_HZ / 1000 * `DCRM_FLASH_MS,
    parameter LINK_TO_CYC = `DCRM_CLK_HZ,
    parameter LED_PULSE_CYC = `DCRM_CLK_HZ / 50
) (
    // clock and reset
    input wire sys_clk_i,
    input wire rst_n_i,
    // ahb-lite slave
    input wire hsel_i,
    input wire [7:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output reg [31:0] hrdata_o,
    output reg hreadyout_o,
    output reg hresp_o,
    // channel telegram strobes (pins, synchronised here)
    input wire [1:0] rx_valid_i,
    input wire [5:0] rx_kind_i,
    input wire [13:0] rx_addr_i,
    input wire [7:0] rx_cfg_i,
    input wire [1:0] rx_move_i,
    input wire [1:0] rx_class2_i,
    input wire [13:0] rx_newaddr_i,
    input wire [1:0] chan_fail_i,
    // main board link
    input wire mb_msg_i,
    input wire mb_fw_update_i,
    // replies
    output reg [1:0] reply_valid_o,
    output reg [3:0] reply_kind_o,
    output reg move_cmd_o,
    output reg [1:0] chan_primary_o,
    output reg [13:0] chan_addr_o,
    output reg [15:0] status_word_four_o,
    output reg static_diag_o,
    // indicators
    output reg [1:0] led_rx_o,
    output reg [1:0] led_cyclic_o,
    output reg led_link_o
);
    // ======================================================
    // input synchronisers, two flops per pin
    reg [23:0] s1_r, s2_r;
    reg [13:0] a1_r, a2_r, n1_r, n2_r;
    always @(posedge sys_clk_i) begin
        s1_r <= {mb_fw_update_i, mb_msg_i, chan_fail_i, rx_class2_i,
                 rx_move_i, rx_cfg_i, rx_kind_i, rx_valid_i};
        s2_r <= s1_r;
        a1_r <= rx_addr_i;
        a2_r <= a1_r;
        n1_r <= rx_newaddr_i;
        n2_r <= n1_r;
    end
    wire [1:0] rv = s2_r[1:0];
    wire [5:0] rk = s2_r[7:2];
    wire [7:0] rc = s2_r[15:8];
    wire [1:0] rm = s2_r[17:16];
    wire [1:0] rc2 = s2_r[19:18];
    wire [1:0] cf = s2_r[21:20];
    wire mb_msg = s2_r[22];
    wire mb_upd = s2_r[23];
    reg mb_msg_d_r;

    // ======================================================
    // state
    reg mode_r; // 0 two-highway, 1 one-highway
    reg prim_r; // index of primary channel
    reg hunt_r;
    reg [5:0] sw_lim_r, sw_sec_r;
    reg [31:0] sec_cnt_r;
    reg [6:0] base_r;
    reg [3:0] cfg_r;
    reg [15:0] param_r;
    reg [3:0] baud_r;
    reg [1:0] stage_r [0:1];
    reg lost_r;
    reg [31:0] link_cnt_r, flash_cnt_r;
    reg [31:0] led_cnt_r [0:1];
    reg last_ch_r;

    // station address of a channel
    function [6:0] ch_addr;
        input m, p, ch;
        input [6:0] b;
        begin
            if (m && (ch != p))
                ch_addr = b + `DCRM_ADDR_OFS;
            else
                ch_addr = b;
        end
    endfunction

    // ======================================================
    // ahb-lite slave, zero wait states, always okay
    reg ph_wr_r, ph_act_r;
    reg [7:0] ph_a_r;
    wire take = hsel_i && htrans_i[1] && hready_i;
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ph_wr_r <= 1'b0;
            ph_act_r <= 1'b0;
            ph_a_r <= 8'h00;
        end else if (hready_i) begin
            ph_act_r <= take;
            ph_wr_r <= take && hwrite_i;
            ph_a_r <= haddr_i;
        end
    end
    wire bw = ph_wr_r;

    // read mux registered from the address phase
    reg [31:0] rd;
    always @* begin
        case (haddr_i)
            `DCRM_A_CTRL: rd = {31'h0, mode_r};
            `DCRM_A_ADDR: rd = {25'h0, base_r};
            `DCRM_A_CFG: rd = {28'h0, cfg_r};
            `DCRM_A_PARAM: rd = {16'h0, param_r};
            `DCRM_A_STAT: rd = {16'h0, status_word_four_o[15:8],
                                1'b0, lost_r, hunt_r, prim_r, 4'h0};
            `DCRM_A_BAUD: rd = {28'h0, baud_r};
            default: rd = 32'h0;
        endcase
    end
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            hrdata_o <= 32'h0;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else if (take && !hwrite_i) begin
            hrdata_o <= rd;
        end
    end

    // ======================================================
    // channel protocol: primary role, hunting, gating
    integer i;
    integer j, k;
    reg rx_hit;
    reg rx_ch;
    always @* begin
        rx_hit = 1'b0;
        rx_ch = last_ch_r;
        for (i = 0; i < 2; i = i + 1) begin
            if (rv[i] && !rx_hit && rk[i*3+:3] != `DCRM_T_SETADR &&
                a2_r[i*7+:7] == ch_addr(mode_r, prim_r, i[0], base_r)) begin
                rx_hit = 1'b1;
                rx_ch = i[0];
            end
        end
    end

    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mode_r <= 1'b0;
            prim_r <= 1'b0;
            hunt_r <= 1'b1;
            sw_lim_r <= `DCRM_SW_MIN_S;
            sw_sec_r <= 6'h0;
            sec_cnt_r <= 32'h0;
            base_r <= `DCRM_ADDR_DEF;
            cfg_r <= `DCRM_CFG_DEF;
            param_r <= 16'h0;
            baud_r <= 4'h0;
            stage_r[0] <= 2'h0;
            stage_r[1] <= 2'h0;
            reply_valid_o <= 2'h0;
            reply_kind_o <= 4'h0;
            move_cmd_o <= 1'b0;
            last_ch_r <= 1'b0;
        end else begin
            reply_valid_o <= 2'h0;
            move_cmd_o <= 1'b0;
            // software writes: mode, base address, baud
            if (bw && ph_a_r == `DCRM_A_CTRL)
                mode_r <= hwdata_i[`DCRM_MODE_BIT];
            if (bw && ph_a_r == `DCRM_A_ADDR)
                base_r <= hwdata_i[6:0] & `DCRM_ADDR_MASK;
            if (bw && ph_a_r == `DCRM_A_BAUD)
                baud_r <= hwdata_i[3:0];
            // hunting: swap primary, doubling interval up to ceiling
            if (hunt_r) begin
                if (sec_cnt_r >= SEC_CYC - 1) begin
                    sec_cnt_r <= 32'h0;
                    if (sw_sec_r + 6'h1 >= sw_lim_r) begin
                        sw_sec_r <= 6'h0;
                        prim_r <= ~prim_r;
                        if (sw_lim_r < `DCRM_SW_MAX_S)
                            sw_lim_r <= sw_lim_r << 1;
                    end else
                        sw_sec_r <= sw_sec_r + 6'h1;
                end else
                    sec_cnt_r <= sec_cnt_r + 32'h1;
            end
            // primary failure hands over role and base address
            if (cf[prim_r] && !cf[~prim_r]) begin
                prim_r <= ~prim_r;
                stage_r[prim_r] <= 2'h0;
            end
            // station address set by class 2 master only at 126
            for (j = 0; j < 2; j = j + 1)
                if (rv[j] && rk[j*3+:3] == `DCRM_T_SETADR && rc2[j] &&
                    base_r == `DCRM_ADDR_DEF) begin
                    base_r <= n2_r[j*7+:7] & `DCRM_ADDR_MASK;
                    reply_valid_o[j] <= 1'b1;
                    reply_kind_o[j*2+:2] <= `DCRM_R_ACK;
                    last_ch_r <= j[0];
                end
            if (rx_hit) begin
                last_ch_r <= rx_ch;
                if (hunt_r) begin
                    hunt_r <= 1'b0;
                    // one-highway: addresses follow the active channel
                    if (mode_r || rx_ch != prim_r)
                        prim_r <= rx_ch;
                end
                reply_valid_o[rx_ch] <= 1'b1;
                case (rk[rx_ch*3+:3])
                    `DCRM_T_DIAG: begin
                        reply_kind_o[rx_ch*2+:2] <= `DCRM_R_DIAG;
                        if (stage_r[rx_ch] == 2'h2 && !lost_r)
                            stage_r[rx_ch] <= 2'h3;
                        else if (stage_r[rx_ch] != 2'h3)
                            stage_r[rx_ch] <= 2'h1;
                    end
                    `DCRM_T_PRM: begin
                        reply_kind_o[rx_ch*2+:2] <= `DCRM_R_ACK;
                        if (rx_ch == prim_r || hunt_r)
                            param_r <= {8'h0, rc[rx_ch*4+:4], 4'h0};
                        if (stage_r[rx_ch] == 2'h1)
                            stage_r[rx_ch] <= 2'h2;
                    end
                    `DCRM_T_CFG: begin
                        // acked either way, applied from primary only
                        reply_kind_o[rx_ch*2+:2] <= `DCRM_R_ACK;
                        if (rx_ch == prim_r || hunt_r)
                            cfg_r <= rc[rx_ch*4+:4];
                    end
                    `DCRM_T_DATA: begin
                        if (stage_r[rx_ch] == 2'h3) begin
                            reply_kind_o[rx_ch*2+:2] <= `DCRM_R_DATA;
                            move_cmd_o <= rm[rx_ch] &&
                                (rx_ch == prim_r);
                        end else
                            reply_kind_o[rx_ch*2+:2] <= `DCRM_R_DIAG;
                    end
                    default: reply_kind_o[rx_ch*2+:2] <= `DCRM_R_NONE;
                endcase
            end
        end
    end

    // ======================================================
    // address, role and status outputs
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            chan_primary_o <= 2'b01;
            chan_addr_o <= {`DCRM_ADDR_DEF, `DCRM_ADDR_DEF};
            status_word_four_o <= 16'h0;
        end else begin
            chan_primary_o <= prim_r ? 2'b10 : 2'b01;
            chan_addr_o <= {ch_addr(mode_r, prim_r, 1'b1, base_r),
                            ch_addr(mode_r, prim_r, 1'b0, base_r)};
            status_word_four_o <= 16'h0;
            status_word_four_o[`DCRM_CHAN_BIT] <=
                (last_ch_r != prim_r);
        end
    end

    // ======================================================
    // main board link watch and static diagnostic bit
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mb_msg_d_r <= 1'b0;
            link_cnt_r <= 32'h0;
            lost_r <= 1'b0;
            static_diag_o <= 1'b0;
        end else begin
            mb_msg_d_r <= mb_msg;
            // silence counter restarts per message, saturates at limit
            if (mb_msg && !mb_msg_d_r)
                link_cnt_r <= 32'h0;
            else if (link_cnt_r < LINK_TO_CYC - 1)
                link_cnt_r <= link_cnt_r + 32'h1;
            // an update halt wins over a message edge in the same cycle
            if (mb_upd || (!(mb_msg && !mb_msg_d_r) &&
                    link_cnt_r >= LINK_TO_CYC - 1))
                lost_r <= 1'b1;
            else if (mb_msg && !mb_msg_d_r)
                lost_r <= 1'b0;
            static_diag_o <= lost_r;
        end
    end

    // ======================================================
    // indicators; pulses stretched so the eye can see them
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            led_rx_o <= 2'h0;
            led_cyclic_o <= 2'h0;
            led_link_o <= 1'b0;
            flash_cnt_r <= 32'h0;
            led_cnt_r[0] <= 32'h0;
            led_cnt_r[1] <= 32'h0;
        end else begin
            for (k = 0; k < 2; k = k + 1) begin
                if (rv[k])
                    led_cnt_r[k] <= LED_PULSE_CYC;
                else if (led_cnt_r[k] != 32'h0)
                    led_cnt_r[k] <= led_cnt_r[k] - 32'h1;
                led_rx_o[k] <= (led_cnt_r[k] != 32'h0);
                led_cyclic_o[k] <= (stage_r[k] == 2'h3);
            end
            if (flash_cnt_r >= FLASH_CYC - 1) begin
                flash_cnt_r <= 32'h0;
                led_link_o <= lost_r ? 1'b0 : ~led_link_o;
            end else
                flash_cnt_r <= flash_cnt_r + 32'h1;
        end
    end
endmodule
`default_nettype wire

// ---- dcrm_defines.vh ----
// constants for the dual channel redundancy manager
// Behaviour
// - two-highway mode: both channels answer at the same station address.
// - after reset channel 1 is primary, channel 2 backup.
// - while idle, swap primary role at growing intervals, capped at 32 s.
// - two-highway mode: primary failure hands primary role to the backup.
// - data exchange allowed on backup, but motion commands there are dropped.
// - differing config on backup is acknowledged but not applied.
// - one-highway mode: primary at base address, backup at base plus 64.
// - writing base address defines backup address as base plus offset.
// - one-highway mode: addresses follow the channel found during hunting.
// - one-highway mode: on primary failure backup takes the primary address.
// - configuration applies only from primary; both channels share it.
// - parameters accepted only from primary and shared by both channels.
// - master picks baud rate; both channels run at that one rate.
// - bit 5 of input status word four tells primary or backup.
// - reset default is two-highway mode; one-highway only by setting.
// - redundancy parameter bit 0: zero two-highway, one one-highway.
// - per channel: receive pulse per message, steady light during exchange.
// - slow flashing light while main board link and power are present.
// - start-up: diagnostic, parameters, config check, diagnostic, in order; code needs only diagnostic, parameters, diagnostic.
// - diag gets data reply, accepted set/check gets short ack.
// - station address reassignable by class 2 master only while it is 126.
// - static diagnostic bit set while main board link is lost.
// - firmware update halts the link: bit raised, cleared when link resumes.
`ifndef DCRM_DEFINES_VH
`define DCRM_DEFINES_VH
// ==========================================================
// bus register map (byte addresses)
`define DCRM_A_CTRL 8'h00
`define DCRM_A_ADDR 8'h04
`define DCRM_A_CFG 8'h08
`define DCRM_A_PARAM 8'h0c
`define DCRM_A_STAT 8'h10
`define DCRM_A_BAUD 8'h14
// ==========================================================
// fields and values
`define DCRM_MODE_BIT 0
`define DCRM_CHAN_BIT 5
`define DCRM_ADDR_OFS 7'h40
`define DCRM_ADDR_DEF 7'h7e
`define DCRM_ADDR_MASK 7'h3f
`define DCRM_CFG_DEF 4'h1
// ==========================================================
// telegram kinds on a channel
`define DCRM_T_DIAG 3'h0
`define DCRM_T_PRM 3'h1
`define DCRM_T_CFG 3'h2
`define DCRM_T_DATA 3'h3
`define DCRM_T_SETADR 3'h4
// replies
`define DCRM_R_NONE 2'h0
`define DCRM_R_DIAG 2'h1
`define DCRM_R_ACK 2'h2
`define DCRM_R_DATA 2'h3
// ==========================================================
// timing
`define DCRM_CLK_HZ 100000000
`define DCRM_SW_MIN_S 6'h01
`define DCRM_SW_MAX_S 6'h20
`define DCRM_FLASH_MS 500
`endif

// ---- dcrm_top_chk.sv ----
// port-level assertion checker for the redundancy manager
`include "dcrm_defines.vh"
`default_nettype none
module dcrm_top_chk #(
    parameter int LINK_TO_CYC = 50
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // watched ports
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic [1:0] rx_valid_i,
    input wire logic mb_msg_i,
    input wire logic mb_fw_update_i,
    input wire logic [1:0] reply_valid_o,
    input wire logic [1:0] chan_primary_o,
    input wire logic [13:0] chan_addr_o,
    input wire logic [15:0] status_word_four_o,
    input wire logic static_diag_o,
    input wire logic [1:0] led_rx_o,
    input wire logic [1:0] led_cyclic_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_r;
    logic mb_q_r;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // ==========================================================
    // cycles since the last main board message edge, saturating
    always @(posedge sys_clk_i) begin
        mb_q_r <= mb_msg_i;
        if (!rst_n_i || (mb_msg_i && !mb_q_r))
            cnt_r <= 0;
        else if (cnt_r < LINK_TO_CYC + 8)
            cnt_r <= cnt_r + 1;
    end
    // ==========================================================
    // assertions
    a_reset_prim: assert property (
        $rose(rst_n_i) |-> chan_primary_o == 2'b01)
        else $error("primary is not channel one after reset");
    a_reset_addr: assert property (
        $rose(rst_n_i) |-> chan_addr_o == {2{`DCRM_ADDR_DEF}})
        else $error("channel addresses differ after reset");
    a_one_primary: assert property ($onehot(chan_primary_o))
        else $error("not exactly one primary channel");
    a_bus_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus slave stalled or gave an error");
    a_addr_pair: assert property (
        chan_addr_o[5:0] == chan_addr_o[12:7])
        else $error("channel addresses not equal or offset by 64");
    a_reply_cause: assert property (
        $rose(reply_valid_o[1]) |-> $past(rx_valid_i[1], 3))
        else $error("reply without a telegram three cycles before");
    a_rx_flash: assert property (
        $rose(rx_valid_i[0]) |-> ##[2:5] led_rx_o[0])
        else $error("receive light missed a telegram");
    a_bit5_primary: assert property (
        reply_valid_o[1] && chan_primary_o[1] |=> !status_word_four_o[5])
        else $error("status bit five shows backup for primary");
    a_fw_raise: assert property (
        mb_fw_update_i [*5] |-> static_diag_o)
        else $error("static bit low during firmware update");
    a_link_timeout: assert property (
        cnt_r == LINK_TO_CYC + 6 |-> static_diag_o)
        else $error("static bit low after link silence");
    a_static_cause: assert property (
        $rose(static_diag_o) |-> cnt_r >= LINK_TO_CYC - 2
            || $past(mb_fw_update_i, 3) || $past(mb_fw_update_i, 4))
        else $error("static bit raised with the link alive");
    // main scenarios reached
    c_reply: cover property (reply_valid_o[1]);
    c_lost: cover property ($rose(static_diag_o));
    c_exchange: cover property (led_cyclic_o[1] && chan_primary_o[1]);
endmodule
bind dcrm_top dcrm_top_chk #(.LINK_TO_CYC(LINK_TO_CYC)) dcrm_top_chk_inst (
    .sys_clk_i, .rst_n_i, .hreadyout_o, .hresp_o, .rx_valid_i, .mb_msg_i,
    .mb_fw_update_i, .reply_valid_o, .chan_primary_o, .chan_addr_o,
    .status_word_four_o, .static_diag_o, .led_rx_o, .led_cyclic_o);
`default_nettype wire

// ---- dcrm_master_model.sv ----
// fieldbus master model driving the channel telegram pins
`include "dcrm_defines.vh"
`default_nettype none
module dcrm_master_model (
    // clock
    input wire logic sys_clk_i,
    // telegram pins toward the device
    output logic [1:0] rx_valid_o,
    output logic [5:0] rx_kind_o,
    output logic [13:0] rx_addr_o,
    output logic [7:0] rx_cfg_o,
    output logic [1:0] rx_move_o,
    output logic [1:0] rx_class2_o,
    output logic [13:0] rx_newaddr_o,
    // device answers
    input wire logic [1:0] reply_valid_i,
    input wire logic [3:0] reply_kind_i,
    input wire logic move_cmd_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // pins quiet until the first telegram
    initial begin
        {rx_valid_o, rx_kind_o, rx_addr_o, rx_cfg_o} = '0;
        {rx_move_o, rx_class2_o, rx_newaddr_o} = '0;
    end
    // one-cycle strobe, fields held while answered, then inverted so
    // the device cannot lean on stale field values
    task automatic tel(input int ch, input logic [2:0] k,
            input logic [6:0] a, input logic [3:0] c, input logic m,
            output logic [1:0] rk, output logic seen);
        rk = `DCRM_R_NONE;
        seen = 1'b0;
        @(posedge sys_clk_i);
        rx_valid_o[ch] <= 1'b1;
        rx_kind_o[ch*3+:3] <= k;
        rx_addr_o[ch*7+:7] <= a;
        rx_newaddr_o[ch*7+:7] <= a;
        rx_cfg_o[ch*4+:4] <= c;
        rx_move_o[ch] <= m;
        rx_class2_o[ch] <= (k == `DCRM_T_SETADR);
        repeat (12) begin
            @(posedge sys_clk_i);
            rx_valid_o[ch] <= 1'b0;
            seen = seen | move_cmd_i;
            if (reply_valid_i[ch] === 1'b1)
                rk = reply_kind_i[ch*2+:2];
        end
        rx_kind_o[ch*3+:3] <= ~k;
        rx_addr_o[ch*7+:7] <= ~a;
        rx_newaddr_o[ch*7+:7] <= ~a;
        rx_cfg_o[ch*4+:4] <= ~c;
        rx_move_o[ch] <= ~m;
        rx_class2_o[ch] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- dcrm_top_tb.sv ----
// self-checking bench for the redundancy manager
`include "dcrm_defines.vh"
`default_nettype none
module dcrm_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] AD = `DCRM_ADDR_DEF;
    logic sys_clk_i, rst_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
    logic mb_msg_i, mb_fw_update_i, mb_run, move_cmd_o, static_diag_o;
    logic led_link_o, mv, lq;
    logic [7:0] haddr_i, rx_cfg_i;
    logic [1:0] htrans_i, chan_fail_i, rx_valid_i, rx_move_i, rx_class2_i;
    logic [1:0] reply_valid_o, chan_primary_o, led_rx_o, led_cyclic_o, rk;
    logic [2:0] hsize_i;
    logic [3:0] reply_kind_o;
    logic [5:0] rx_kind_i;
    logic [13:0] rx_addr_i, rx_newaddr_i, chan_addr_o;
    logic [15:0] status_word_four_o;
    logic [31:0] hwdata_i, hrdata_o, v;
    int fails, n_tests, n;
    int hw[4] = '{5, 15, 30, 60};
    // ==========================================================
    // device and master model
    dcrm_top #(.SEC_CYC(10), .FLASH_CYC(4), .LINK_TO_CYC(50),
        .LED_PULSE_CYC(3)) dcrm_top_inst (.sys_clk_i, .rst_n_i, .hsel_i,
        .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
        .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
        .rx_valid_i, .rx_kind_i, .rx_addr_i, .rx_cfg_i, .rx_move_i,
        .rx_class2_i, .rx_newaddr_i, .chan_fail_i, .mb_msg_i,
        .mb_fw_update_i, .reply_valid_o, .reply_kind_o, .move_cmd_o,
        .chan_primary_o, .chan_addr_o, .status_word_four_o, .static_diag_o,
        .led_rx_o, .led_cyclic_o, .led_link_o);
    dcrm_master_model dcrm_master_model_inst (.sys_clk_i,
        .rx_valid_o(rx_valid_i), .rx_kind_o(rx_kind_i),
        .rx_addr_o(rx_addr_i), .rx_cfg_o(rx_cfg_i), .rx_move_o(rx_move_i),
        .rx_class2_o(rx_class2_i), .rx_newaddr_o(rx_newaddr_i),
        .reply_valid_i(reply_valid_o), .reply_kind_i(reply_kind_o),
        .move_cmd_i(move_cmd_o));
    // ==========================================================
    // 100 mhz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    // main board heartbeat: a rising edge every 20 cycles while enabled
    initial begin
        forever begin
            repeat (10) @(posedge sys_clk_i);
            if (mb_run)
                mb_msg_i <= ~mb_msg_i;
        end
    end
    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        fails++;
        test_done();
    end
    // ==========================================================
    task automatic chk(input string nm, input logic [31:0] got,
            input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // single ahb-lite word transfer; read data lands in v
    task automatic ahb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge sys_clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= w;
        do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
        v = hrdata_o;
    endtask
    // one telegram and a check of its answer
    task automatic tx(input int ch, input logic [2:0] k, input logic [6:0] a,
            input logic [3:0] c, input logic m, input logic [1:0] er,
            input logic em);
        dcrm_master_model_inst.tel(ch, k, a, c, m, rk, mv);
        chk("reply kind", rk, er);
        chk("motion", mv, em);
    endtask
    task automatic tend(input string nm);
        $display("test %s finished, %0d mismatches so far", nm, fails);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    initial begin
        {hsel_i, hwrite_i, mb_msg_i, mb_fw_update_i} = '0;
        {htrans_i, chan_fail_i, haddr_i, hwdata_i} = '0;
        hsize_i = 3'h2;
        mb_run = 1'b1;
        rst_n_i = 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        // idle hunting: spans of 10, 20, 40, 80 cycles
        foreach (hw[i]) begin
            repeat (hw[i]) @(posedge sys_clk_i);
            chk("primary", chan_primary_o, i % 2 ? 2'b10 : 2'b01);
        end
        tend("hunting");
        // start-up on channel two, now primary
        tx(1, `DCRM_T_DIAG, AD, 4'h0, 1'b0, `DCRM_R_DIAG, 1'b0);
        tx(1, `DCRM_T_PRM, AD, 4'h6, 1'b0, `DCRM_R_ACK, 1'b0);
        tx(1, `DCRM_T_CFG, AD, 4'h3, 1'b0, `DCRM_R_ACK, 1'b0);
        tx(1, `DCRM_T_DIAG, AD, 4'h0, 1'b0, `DCRM_R_DIAG, 1'b0);
        chk("cyclic light", led_cyclic_o, 2'b10);
        tx(1, `DCRM_T_DATA, AD, 4'h0, 1'b1, `DCRM_R_DATA, 1'b1);
        chk("channel bit", status_word_four_o[5], 1'b0);
        tend("startup");
        // backup channel one: own start-up, data yes, motion, settings no
        tx(0, `DCRM_T_DIAG, AD, 4'h0, 1'b0, `DCRM_R_DIAG, 1'b0);
        tx(0, `DCRM_T_PRM, AD, 4'h8, 1'b0, `DCRM_R_ACK, 1'b0);
        tx(0, `DCRM_T_DIAG, AD, 4'h0, 1'b0, `DCRM_R_DIAG, 1'b0);
        tx(0, `DCRM_T_DATA, AD, 4'h0, 1'b1, `DCRM_R_DATA, 1'b0);
        chk("channel bit", status_word_four_o[5], 1'b1);
        tx(0, `DCRM_T_CFG, AD, 4'h5, 1'b0, `DCRM_R_ACK, 1'b0);
        ahb(1'b0, `DCRM_A_CFG, 32'h0);
        chk("config", v[3:0], 4'h3);
        ahb(1'b0, `DCRM_A_PARAM, 32'h0);
        chk("param", v[7:4], 4'h6);
        chk("primary", chan_primary_o, 2'b10);
        tend("backup");
        // address set by class 2 only while at 126, baud, unmapped
        dcrm_master_model_inst.tel(1, `DCRM_T_SETADR, 7'h0a, 4'h0, 1'b0, rk,
            mv);
        chk("address", chan_addr_o, {2{7'h0a}});
        dcrm_master_model_inst.tel(1, `DCRM_T_SETADR, 7'h14, 4'h0, 1'b0, rk,
            mv);
        chk("address", chan_addr_o, {2{7'h0a}});
        ahb(1'b1, `DCRM_A_BAUD, 32'h3);
        ahb(1'b0, `DCRM_A_BAUD, 32'h0);
        chk("baud", v[3:0], 4'h3);
        ahb(1'b0, 8'h20, 32'h0);
        chk("unmapped", v, 32'h0);
        ahb(1'b0, `DCRM_A_CTRL, 32'h0);
        chk("mode", v[0], 1'b0);
        tend("address");
        // two-highway failover
        chan_fail_i <= 2'b10;
        repeat (6) @(posedge sys_clk_i);
        chk("primary", chan_primary_o, 2'b01);
        chan_fail_i <= 2'b00;
        // one-highway mode, base 5, backup at 69
        ahb(1'b1, `DCRM_A_CTRL, 32'h1);
        ahb(1'b1, `DCRM_A_ADDR, 32'h5);
        repeat (2) @(posedge sys_clk_i);
        chk("address", chan_addr_o, {7'h45, 7'h05});
        tx(1, `DCRM_T_DIAG, 7'h45, 4'h0, 1'b0, `DCRM_R_DIAG, 1'b0);
        tx(1, `DCRM_T_DIAG, 7'h05, 4'h0, 1'b0, `DCRM_R_NONE, 1'b0);
        chan_fail_i <= 2'b01;
        repeat (6) @(posedge sys_clk_i);
        chk("primary", chan_primary_o, 2'b10);
        chk("address", chan_addr_o[13:7], 7'h05);
        ahb(1'b0, `DCRM_A_STAT, 32'h0);
        chk("status", v, 32'h10);
        chan_fail_i <= 2'b00;
        tend("one highway");
        // link light flashes, then link loss and firmware update
        n = 0;
        lq = led_link_o;
        repeat (20) begin
            @(posedge sys_clk_i);
            n += (led_link_o !== lq);
            lq = led_link_o;
        end
        chk("flash", n >= 2, 1'b1);
        mb_run <= 1'b0;
        repeat (80) @(posedge sys_clk_i);
        chk("static", static_diag_o, 1'b1);
        mb_run <= 1'b1;
        repeat (30) @(posedge sys_clk_i);
        chk("static", static_diag_o, 1'b0);
        mb_fw_update_i <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        chk("static", static_diag_o, 1'b1);
        mb_fw_update_i <= 1'b0;
        repeat (30) @(posedge sys_clk_i);
        chk("static", static_diag_o, 1'b0);
        tend("link");
        test_done();
    end
endmodule
`default_nettype wire
